// ===== fm_rx_prop_map.vh
/*
 * Property offsets, field positions, reset values and timing counts for the
 * FM receiver configuration property bank.
 * Assumes a 250 MHz core clock and a property command port of 16-bit data.
 */
// Operation
// - divide external reference by programmed prescaler, legal 1 to 4095
// - prescaler sits in bits 11:0; bits 15:12 reserved, written zero
// - accept flag set after each access; controller waits for it
// - property accesses accepted only in powered-up mode
// - de-emphasis code 10 is 75 us, 01 is 50 us; others reserved
// - filter code 0 automatic, 1 to 4 force 110/84/60/40 kHz
// - above stereo level full stereo, below blended; 7-bit level
// - below mono level full mono, above blended or stereo; 7-bit
// - level 0 forces stereo, level 127 forces mono
// - antenna bit 0 picks long pin at 0, short pin at 1
`ifndef FM_RX_PROP_MAP_VH
`define FM_RX_PROP_MAP_VH

// ----------------------------------------
// property offsets
// ----------------------------------------
`define OFS_REF_DIV 16'h0202
`define OFS_EMPH 16'h1100
`define OFS_CHAN_BW 16'h1102
`define OFS_STEREO_LVL 16'h1105
`define OFS_MONO_LVL 16'h1106
`define OFS_ANTENNA 16'h1107

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_REF_DIV 12'h001
`define RST_EMPH 2'h2
`define RST_CHAN_BW 3'h1
`define RST_STEREO_LVL 7'h31
`define RST_MONO_LVL 7'h1e
`define RST_ANTENNA 1'h0

// ----------------------------------------
// fields and codes
// ----------------------------------------
`define DIV_MSB 11
`define DIV_MAX 12'hfff
`define EMPH_MSB 1
`define EMPH_75US 2'h2
`define EMPH_50US 2'h1
`define BW_MAX 3'h4
`define LVL_MSB 6
`define LVL_FORCE_MONO 7'h7f
`define ANT_BIT 0

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 4
`define ACCEPT_DELAY_NS 20
`define ACCEPT_DELAY_CYC ((`ACCEPT_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== fm_rx_config_property_bank.v
/*
 * Configuration property bank of the FM receiver: holds reference divider,
 * de-emphasis, channel filter, blend levels and antenna select, and divides
 * the synchronised external reference down to the internal reference.
 * Assumes the controller issues one property command at a time over the
 * command port and waits for cmdAccept before the next.
 */
`timescale 1ns/1ps
`include "fm_rx_prop_map.vh"
`default_nettype none

module fm_rx_config_property_bank
(
   // clock and reset
   input wire clk,
   input wire resetn,
   input wire clkEn,
   // mode
   input wire poweredUp,
   // property command port
   input wire cmdValid,
   input wire cmdWrite,
   input wire [15:0] cmdAddr,
   input wire [15:0] cmdWdata,
   output reg [15:0] cmdRdata,
   output wire cmdAccept,
   output reg cmdError,
   // external reference and derived clock
   input wire extRefClk,
   output reg internal_reference_clock,
   // receiver controls
   input wire [6:0] rssiLevel,
   output reg [1:0] emphasis_time_constant,
   output reg [2:0] channel_bw_code,
   output reg [6:0] stereo_rssi_level,
   output reg [6:0] single_channel_rssi_level,
   output reg short_antenna_enable,
   output reg stereoFull,
   output reg monoFull,
   output reg emphasis75us
);

   // ----------------------------------------
   // property registers
   // ----------------------------------------
   reg [11:0] reference_divider_value;
   reg [3:0] acceptCnt_ff;
   reg busy_ff;
   // settle count, cut to the counter's width where it is loaded
   localparam integer ACCEPT_CYC = `ACCEPT_DELAY_CYC;
   wire legalMode = poweredUp;
   wire take = clkEn & cmdValid & ~busy_ff;

   function hitAddr;
      input [15:0] addr;
      input [15:0] ofs;
      begin
         hitAddr = (addr == ofs);
      end
   endfunction

   wire mapped = hitAddr(cmdAddr, `OFS_REF_DIV) | hitAddr(cmdAddr, `OFS_EMPH)
      | hitAddr(cmdAddr, `OFS_CHAN_BW) | hitAddr(cmdAddr, `OFS_STEREO_LVL)
      | hitAddr(cmdAddr, `OFS_MONO_LVL) | hitAddr(cmdAddr, `OFS_ANTENNA);

   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         reference_divider_value <= `RST_REF_DIV;
         emphasis_time_constant <= `RST_EMPH;
         channel_bw_code <= `RST_CHAN_BW;
         stereo_rssi_level <= `RST_STEREO_LVL;
         single_channel_rssi_level <= `RST_MONO_LVL;
         short_antenna_enable <= `RST_ANTENNA;
         cmdRdata <= 16'h0000;
         cmdError <= 1'b0;
      end
      else if (take)
      begin
         // accesses outside powered-up mode are refused and flagged
         cmdError <= ~legalMode | ~mapped;
         if (legalMode & cmdWrite)
         begin
            // out-of-range divider, de-emphasis and filter values leave the old setting untouched; levels and antenna take the low bits
            if (hitAddr(cmdAddr, `OFS_REF_DIV) && cmdWdata[15:12] == 4'h0
               && cmdWdata[`DIV_MSB:0] != 12'h000)
               reference_divider_value <= cmdWdata[`DIV_MSB:0];
            if (hitAddr(cmdAddr, `OFS_EMPH) && cmdWdata[15:2] == 14'h0000
               && (cmdWdata[`EMPH_MSB:0] == `EMPH_75US
               || cmdWdata[`EMPH_MSB:0] == `EMPH_50US))
               emphasis_time_constant <= cmdWdata[`EMPH_MSB:0];
            if (hitAddr(cmdAddr, `OFS_CHAN_BW) && cmdWdata <= {13'h0000, `BW_MAX})
               channel_bw_code <= cmdWdata[2:0];
            if (hitAddr(cmdAddr, `OFS_STEREO_LVL))
               stereo_rssi_level <= cmdWdata[`LVL_MSB:0];
            if (hitAddr(cmdAddr, `OFS_MONO_LVL))
               single_channel_rssi_level <= cmdWdata[`LVL_MSB:0];
            if (hitAddr(cmdAddr, `OFS_ANTENNA))
               short_antenna_enable <= cmdWdata[`ANT_BIT];
         end
         if (!legalMode || cmdWrite)
            cmdRdata <= 16'h0000;
         else if (hitAddr(cmdAddr, `OFS_REF_DIV))
            cmdRdata <= {4'h0, reference_divider_value};
         else if (hitAddr(cmdAddr, `OFS_EMPH))
            cmdRdata <= {14'h0000, emphasis_time_constant};
         else if (hitAddr(cmdAddr, `OFS_CHAN_BW))
            cmdRdata <= {13'h0000, channel_bw_code};
         else if (hitAddr(cmdAddr, `OFS_STEREO_LVL))
            cmdRdata <= {9'h000, stereo_rssi_level};
         else if (hitAddr(cmdAddr, `OFS_MONO_LVL))
            cmdRdata <= {9'h000, single_channel_rssi_level};
         else if (hitAddr(cmdAddr, `OFS_ANTENNA))
            cmdRdata <= {15'h0000, short_antenna_enable};
         else
            cmdRdata <= 16'h0000;
      end
   end

   // ----------------------------------------
   // accept flag
   // ----------------------------------------
   // busy holds off a second command until the settle delay has run out
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         busy_ff <= 1'b0;
         acceptCnt_ff <= 4'h0;
      end
      else if (clkEn)
      begin
         if (take)
         begin
            busy_ff <= 1'b1;
            acceptCnt_ff <= ACCEPT_CYC[3:0];
         end
         else if (busy_ff)
         begin
            if (acceptCnt_ff == 4'h1)
               busy_ff <= 1'b0;
            acceptCnt_ff <= acceptCnt_ff - 4'h1;
         end
      end
   end
   assign cmdAccept = ~busy_ff;

   // ----------------------------------------
   // reference prescaler
   // ----------------------------------------
   reg refSync1_ff, refSync2_ff, refSync3_ff, refState_ff;
   reg [11:0] edgeCnt_ff;
   wire refStable = (refSync2_ff == refSync3_ff);
   wire refRise = refStable & refSync2_ff & ~refState_ff;
   wire [11:0] halfLo = reference_divider_value >> 1;
   wire [11:0] halfHi = reference_divider_value - halfLo;

   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         refSync1_ff <= 1'b0;
         refSync2_ff <= 1'b0;
         refSync3_ff <= 1'b0;
         refState_ff <= 1'b0;
         edgeCnt_ff <= 12'h000;
         internal_reference_clock <= 1'b0;
      end
      else if (clkEn)
      begin
         refSync1_ff <= extRefClk;
         refSync2_ff <= refSync1_ff;
         refSync3_ff <= refSync2_ff;
         if (refStable)
            refState_ff <= refSync2_ff;
         // divide by one passes the settled reference straight through
         if (reference_divider_value == 12'h001)
         begin
            if (refStable)
               internal_reference_clock <= refSync2_ff;
         end
         // count rising edges; output toggles every half period of edges
         else if (refRise)
         begin
            if (edgeCnt_ff + 12'h001 >=
               (internal_reference_clock ? halfLo : halfHi))
            begin
               edgeCnt_ff <= 12'h000;
               internal_reference_clock <= ~internal_reference_clock;
            end
            else
               edgeCnt_ff <= edgeCnt_ff + 12'h001;
         end
      end
   end

   // ----------------------------------------
   // blend and de-emphasis decode
   // ----------------------------------------
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         stereoFull <= 1'b0;
         monoFull <= 1'b0;
         emphasis75us <= 1'b1;
      end
      else if (clkEn)
      begin
         // level 0 always stereo, 127 always mono; mono wins a conflict
         monoFull <= (single_channel_rssi_level == `LVL_FORCE_MONO)
            | (stereo_rssi_level == `LVL_FORCE_MONO)
            | (rssiLevel < single_channel_rssi_level);
         stereoFull <= (stereo_rssi_level != `LVL_FORCE_MONO)
            & (single_channel_rssi_level != `LVL_FORCE_MONO)
            & ((stereo_rssi_level == 7'h00) | (single_channel_rssi_level == 7'h00)
            | (rssiLevel > stereo_rssi_level));
         emphasis75us <= (emphasis_time_constant == `EMPH_75US);
      end
   end

endmodule // fm_rx_config_property_bank

`default_nettype wire

// ===== fm_rx_bank_properties.sv
/* command port and decode checker for the property bank
   accept timing assumes clkEn high while busy; level checks skip frozen edges */
`timescale 1ns/1ps
`default_nettype none
module fm_rx_bank_chk
(
   // control and command port
   input wire clk, input wire resetn, input wire clkEn, input wire poweredUp,
   input wire cmdValid, input wire cmdWrite, input wire [15:0] cmdAddr,
   input wire [15:0] cmdWdata, input wire cmdAccept, input wire cmdError,
   // fields and decodes
   input wire [1:0] emphasis_time_constant, input wire [2:0] channel_bw_code,
   input wire [6:0] stereo_rssi_level, input wire [6:0] single_channel_rssi_level,
   input wire short_antenna_enable, input wire stereoFull, input wire monoFull,
   input wire [6:0] rssiLevel
);
wire tk = clkEn & cmdValid & cmdAccept;
wire wr = tk & cmdWrite & poweredUp;
wire [1:0] em = emphasis_time_constant;
wire [6:0] mo = single_channel_rssi_level;
default clocking @(posedge clk); endclocking
default disable iff (!resetn);
property p_busy; tk |=> !cmdAccept [*5] ##1 cmdAccept; endproperty
a_busy: assert property (p_busy) else $error("accept timing");
property p_off; tk & !poweredUp |=> cmdError & $stable(em); endproperty
a_off: assert property (p_off) else $error("unpowered access");
property p_err; tk & poweredUp |=> cmdError == !($past(cmdAddr) inside {16'h0202,
   16'h1100, 16'h1102, 16'h1105, 16'h1106, 16'h1107}); endproperty
a_err: assert property (p_err) else $error("error flag");
property p_em; wr && cmdAddr == 16'h1100 |=> ($past(cmdWdata) inside {16'h1, 16'h2}) ?
   {14'h0, em} == $past(cmdWdata) : $stable(em); endproperty
a_em: assert property (p_em) else $error("emphasis");
property p_bw; wr && cmdAddr == 16'h1102 |=> $past(cmdWdata) > 16'h4 ?
   $stable(channel_bw_code) : {13'h0, channel_bw_code} == $past(cmdWdata); endproperty
a_bw: assert property (p_bw) else $error("filter code");
property p_ant; wr && cmdAddr == 16'h1107 && cmdWdata < 16'h2 |=>
   {15'h0, short_antenna_enable} == $past(cmdWdata); endproperty
a_ant: assert property (p_ant) else $error("antenna");
property p_mono; mo == 7'h7f |=> monoFull & !stereoFull; endproperty
a_mono: assert property (p_mono) else $error("forced mono");
property p_st; (stereo_rssi_level == 7'h0 || mo == 7'h0) && mo != 7'h7f
   && stereo_rssi_level != 7'h7f |=> stereoFull; endproperty
a_st: assert property (p_st) else $error("forced stereo");
property p_stl; clkEn && rssiLevel > stereo_rssi_level && stereo_rssi_level != 7'h7f
   && mo != 7'h7f |=> stereoFull; endproperty
a_stl: assert property (p_stl) else $error("stereo above level");
property p_bld; clkEn && rssiLevel <= stereo_rssi_level && stereo_rssi_level != 7'h0
   && mo != 7'h0 |=> !stereoFull; endproperty
a_bld: assert property (p_bld) else $error("blend below level");
property p_mnl; clkEn && rssiLevel < mo |=> monoFull; endproperty
a_mnl: assert property (p_mnl) else $error("mono below level");
endmodule // fm_rx_bank_chk
bind fm_rx_config_property_bank fm_rx_bank_chk chk_u (.clk(clk), .resetn(resetn),
   .clkEn(clkEn), .poweredUp(poweredUp), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
   .cmdAddr(cmdAddr), .cmdWdata(cmdWdata), .cmdAccept(cmdAccept), .cmdError(cmdError),
   .emphasis_time_constant(emphasis_time_constant), .channel_bw_code(channel_bw_code),
   .stereo_rssi_level(stereo_rssi_level),
   .single_channel_rssi_level(single_channel_rssi_level),
   .short_antenna_enable(short_antenna_enable), .stereoFull(stereoFull),
   .monoFull(monoFull), .rssiLevel(rssiLevel));
`default_nettype wire

// ===== fm_rx_ctrl_model.sv
/* controller model: one property command per accept flag
   assumes the bank samples on the rising clk edge */
`timescale 1ns/1ps
`default_nettype none
module fm_rx_ctrl_model
(
   // from bank
   input wire clk, input wire cmdAccept, input wire [15:0] cmdRdata, input wire cmdError,
   // to bank
   output logic cmdValid, output logic cmdWrite, output logic [15:0] cmdAddr,
   output logic [15:0] cmdWdata
);
initial {cmdValid, cmdWrite, cmdAddr, cmdWdata} = 34'h0;
// random idle gap covers slow masters; released lines show inverted data
task automatic xfer(input logic w, input logic [15:0] a, d, output logic [15:0] rd,
   output logic er);
   int n;
   repeat (1 + $urandom % 3) @(posedge clk);
   #1;
   // a new command goes out once the accept flag is back, or after 50 cycles without it
   for (n = 0; cmdAccept !== 1'b1 && n < 50; n++) @(posedge clk) #1;
   {cmdValid, cmdWrite, cmdAddr, cmdWdata} = {1'b1, w, a, d};
   @(posedge clk) #1 rd = cmdRdata;
   er = cmdError;
   {cmdValid, cmdAddr, cmdWdata} = {1'b0, ~a, ~d};
endtask
endmodule // fm_rx_ctrl_model
`default_nettype wire

// ===== tb_top.sv
/* property bank testbench with controller model
   needs bank, model and checker compiled first */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
logic clk = 0, resetn = 0, clkEn = 1, poweredUp = 1, extRefClk = 0, er;
logic cmdValid, cmdWrite, cmdAccept, cmdError, irc, stereoFull, monoFull, emphasis75us;
logic [15:0] cmdAddr, cmdWdata, cmdRdata, rd, d;
logic [6:0] rssiLevel = 0;
int errors = 0, tests_run = 0, ticks = 0, i;
logic [15:0] ofs [6] = '{16'h0202, 16'h1100, 16'h1102, 16'h1105, 16'h1106, 16'h1107};
logic [15:0] shd [6] = '{16'h0001, 16'h0002, 16'h0001, 16'h0031, 16'h001e, 16'h0000};
logic [19:0] cor [12] = '{20'h00000, 20'h01003, 20'h00fff, 20'h10000, 20'h10003, 20'h10001,
   20'h10002, 20'h20005, 20'h20004, 20'h30000, 20'h4007f, 20'h50001};
initial forever #2 clk = ~clk;
// reference never stops, so tune margins always hold
initial forever #12 extRefClk = ~extRefClk;
always @(posedge clk) rssiLevel <= #1 7'($urandom);
always @(posedge irc) ticks++;
fm_rx_config_property_bank dut_u (.clk, .resetn, .clkEn, .poweredUp, .cmdValid, .cmdWrite,
   .cmdAddr, .cmdWdata, .cmdRdata, .cmdAccept, .cmdError, .extRefClk,
   .internal_reference_clock(irc), .rssiLevel, .emphasis_time_constant(), .channel_bw_code(),
   .stereo_rssi_level(), .single_channel_rssi_level(), .short_antenna_enable(), .stereoFull,
   .monoFull, .emphasis75us);
fm_rx_ctrl_model ctl_u (.clk, .cmdAccept, .cmdRdata, .cmdError, .cmdValid, .cmdWrite,
   .cmdAddr, .cmdWdata);
task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
   tests_run++;
   errors += int'(got !== exp);
   if (got !== exp)
      $display("FAIL %s expected %h seen %h", what, exp, got);
endtask
function automatic logic [15:0] nxt(int n, logic [15:0] o, logic [15:0] v);
   case (n)
      0: return (v != 0 && v < 16'h1000) ? v : o;
      1: return (v == 1 || v == 2) ? v : o;
      2: return v <= 4 ? v : o;
      5: return v & 16'h1;
      default: return v & 16'h7f;
   endcase
endfunction
task automatic put(int n, logic w, logic [15:0] v);
   if (w) ctl_u.xfer(1'b1, ofs[n], v, rd, er);
   if (w && poweredUp) shd[n] = nxt(n, shd[n], v);
   ctl_u.xfer(1'b0, ofs[n], 16'h0, rd, er);
   chk("read data", poweredUp ? shd[n] : 16'h0, rd);
   chk("error flag", {15'h0, !poweredUp}, {15'h0, er});
endtask
task automatic results;
   $display("checks %0d mismatches %0d", tests_run, errors);
   if (errors == 0 && tests_run > 0)
      $display("No errors found");
   else
      $display("Errors were found");
   $finish;
endtask
initial
begin
   void'($urandom(32'h7f8b52d1));
   repeat (3) @(posedge clk);
   #1 resetn = 1;
   for (i = 0; i < 6; i++) put(i, 1'b0, 16'h0);
   ticks = 0;
   repeat (600) @(posedge clk);
   chk("ref edges div1", 16'd100, 16'(ticks == 99 ? 100 : ticks));
   put(0, 1'b1, 16'h0003);
   ticks = 0;
   repeat (600) @(posedge clk);
   chk("ref edges", 16'd33, 16'(ticks == 34 ? 33 : ticks));
   foreach (cor[k]) put(cor[k][19:16], 1'b1, cor[k][15:0]);
   chk("mono decode", 16'h1, {15'h0, monoFull});
   chk("75us decode", 16'h1, {15'h0, emphasis75us});
   poweredUp = 0;
   put(1, 1'b1, 16'h0001);
   poweredUp = 1;
   put(1, 1'b0, 16'h0);
   ctl_u.xfer(1'b0, 16'h1104, 16'h0, rd, er);
   chk("unmapped flag", 16'h1, {15'h0, er});
   // a frozen bank must ignore a command, so emphasis stays at 75 us
   repeat (6) @(posedge clk);
   #1 clkEn = 0;
   ctl_u.xfer(1'b1, ofs[1], 16'h0001, rd, er);
   clkEn = 1;
   put(1, 1'b0, 16'h0);
   repeat (40)
   begin
      i = $urandom % 6;
      d = $urandom >> ($urandom % 17);
      put(i, 1'b1, i == 5 ? d & 16'h1 : d);
   end
   // 41.7 MHz reference over 1271 lands near 32.8 kHz
   put(0, 1'b1, 16'h04f7);
   results();
end
initial
begin
   #100000 errors++;
   results();
end
endmodule // tb_top
`default_nettype wire
